// >>> rtl/ild_delay.sv
// programmable delay line for an indicator level
`timescale 1ns/1ps
module ild_delay
	import ild_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic din,
	input wire logic [ILD_LAT_W-1:0] latency,
	output logic dout
);
	logic [ILD_LAT_MAX-1:0] taps;

	// =========================================
	// shift chain, tap picked by latency
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			taps <= '0;
		end else begin
			taps <= {taps[ILD_LAT_MAX-2:0], din};
		end
	end

	assign dout = (latency == 3'h0) ? din : taps[latency - 3'h1];

	// a_latency_tap: tap equals delayed input
	a_latency_tap: assert property (@(posedge clk) disable iff (!rst_b)
		(latency == 3'h2 && $stable(latency)) |-> ##2 (dout == $past(din, 2) || latency != 3'h2))
		else $error("latency tap mismatch");
endmodule

// >>> rtl/ild_detector.sv
// one channel of threshold and dwell detection
`timescale 1ns/1ps
module ild_detector
	import ild_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ILD_SAMPLE_W-1:0] sample,
	input wire ild_cfg_t cfg,
	output logic active
);
	ild_state_t state;
	logic [ILD_DWELL_W-1:0] count;
	logic [ILD_THR_W-1:0] top;
	logic at_low;
	logic at_high;

	assign top = ild_top_bits(sample);
	assign at_low = top <= cfg.lower;
	assign at_high = top >= cfg.upper;

	// =========================================
	// state and dwell counter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ILD_IDLE;
			count <= ILD_DWELL_RST;
		end else if (cfg.dwell == ILD_DWELL_RST) begin
			state <= ILD_IDLE;
			count <= ILD_DWELL_RST;
		end else begin
			case (state)
				ILD_IDLE: begin
					if (at_high) begin
						state <= ILD_HIGH;
					end
				end
				ILD_HIGH: begin
					if (at_low && !at_high) begin
						state <= ILD_DWELL;
						count <= cfg.dwell - 20'h00001;
					end
				end
				ILD_DWELL: begin
					if (!at_low || at_high) begin
						state <= ILD_HIGH;
						count <= cfg.dwell;
					end else if (count <= 20'h00001) begin
						state <= ILD_IDLE;
						count <= ILD_DWELL_RST;
					end else begin
						count <= count - 20'h00001;
					end
				end
				default: begin
					state <= ILD_IDLE;
				end
			endcase
		end
	end

	assign active = state != ILD_IDLE;

	// a_zero_dwell_off: disabled detector never goes active
	a_zero_dwell_off: assert property (@(posedge clk) disable iff (!rst_b)
		(cfg.dwell == 20'h00000) |=> (state == ILD_IDLE))
		else $error("detector active with zero dwell");
	// a_high_sets_active
	a_high_sets_active: assert property (@(posedge clk) disable iff (!rst_b)
		(at_high && cfg.dwell != 20'h00000) |=> active)
		else $error("upper excursion did not activate");
	// a_dwell_one_release
	sequence s_low_after_high;
		state == ILD_HIGH && at_low && !at_high && cfg.dwell == 20'h00001 ##1 at_low && !at_high;
	endsequence
	a_dwell_one_release: assert property (@(posedge clk) disable iff (!rst_b)
		s_low_after_high |=> state == ILD_IDLE)
		else $error("dwell of one did not release");
	// a_rise_reloads
	a_rise_reloads: assert property (@(posedge clk) disable iff (!rst_b)
		(state == ILD_DWELL && !at_low && cfg.dwell != 20'h00000) |=> (state == ILD_HIGH))
		else $error("rise during dwell did not reload");
endmodule

// >>> rtl/ild_pkg.sv
// package for the input level detector
package ild_pkg;
	localparam int ILD_THR_W = 10;
	localparam int ILD_DWELL_W = 20;
	localparam int ILD_CTRL_W = 5;
	localparam int ILD_SAMPLE_W = 16;
	localparam int ILD_ADDR_W = 3;
	localparam int ILD_DATA_W = 20;
	localparam int ILD_LAT_W = 3;
	localparam int ILD_LAT_MAX = 7;
	// channel addresses
	localparam logic [2:0] ILD_LOWER_A = 3'h0;
	localparam logic [2:0] ILD_UPPER_A = 3'h1;
	localparam logic [2:0] ILD_DWELL_A = 3'h2;
	localparam logic [2:0] ILD_CTRL_A = 3'h3;
	localparam logic [2:0] ILD_LOWER_B = 3'h4;
	localparam logic [2:0] ILD_UPPER_B = 3'h5;
	localparam logic [2:0] ILD_DWELL_B = 3'h6;
	localparam logic [2:0] ILD_CTRL_B = 3'h7;
	// control fields
	localparam int ILD_POL_BIT = 4;
	localparam int ILD_RSV_BIT = 3;
	localparam int ILD_LAT_LSB = 0;
	// reset values
	localparam logic [9:0] ILD_THR_RST = 10'h000;
	localparam logic [19:0] ILD_DWELL_RST = 20'h00000;
	localparam logic [4:0] ILD_CTRL_RST = 5'h00;

	typedef struct packed {
		logic [ILD_THR_W-1:0] lower;
		logic [ILD_THR_W-1:0] upper;
		logic [ILD_DWELL_W-1:0] dwell;
		logic polarity;
		logic [ILD_LAT_W-1:0] latency;
	} ild_cfg_t;

	typedef enum logic [1:0] {
		ILD_IDLE = 2'b00,
		ILD_HIGH = 2'b01,
		ILD_DWELL = 2'b10
	} ild_state_t;

	function automatic logic [ILD_THR_W-1:0] ild_top_bits(input logic [ILD_SAMPLE_W-1:0] s);
		return s[ILD_SAMPLE_W-1 -: ILD_THR_W];
	endfunction
endpackage

// >>> rtl/ild_top.sv
// two-channel input level detector with channel address access
`timescale 1ns/1ps
// =========================================
module ild_top
	import ild_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic GAIN_CTRL_EN,
	input wire logic [ILD_ADDR_W-1:0] CHANNEL_ADDRESS_REG,
	input wire logic WR,
	input wire logic RD,
	input wire logic [ILD_DATA_W-1:0] WDATA,
	output logic [ILD_DATA_W-1:0] RDATA,
	input wire logic [ILD_SAMPLE_W-1:0] SAMPLE_A,
	input wire logic [ILD_SAMPLE_W-1:0] SAMPLE_B,
	output logic GAIN_FLAG_A,
	output logic GAIN_FLAG_A_N,
	output logic GAIN_FLAG_B,
	output logic GAIN_FLAG_B_N
);
	ild_cfg_t cfg_a;
	ild_cfg_t cfg_b;
	logic [ILD_THR_W-1:0] lower_a;
	logic [ILD_THR_W-1:0] upper_a;
	logic [ILD_DWELL_W-1:0] dwell_a;
	logic [ILD_THR_W-1:0] lower_b;
	logic [ILD_THR_W-1:0] upper_b;
	logic [ILD_DWELL_W-1:0] dwell_b;
	logic [ILD_CTRL_W-1:0] ctrl_a;
	logic [ILD_CTRL_W-1:0] ctrl_b;
	logic act_a;
	logic act_b;
	logic del_a;
	logic del_b;
	logic wr_ok;
	logic [ILD_DATA_W-1:0] next_rdata;

	// writes only with gain control access enabled
	assign wr_ok = WR && GAIN_CTRL_EN;

	// =========================================
	// register file
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			lower_a <= ILD_THR_RST;
			upper_a <= ILD_THR_RST;
			dwell_a <= ILD_DWELL_RST;
			lower_b <= ILD_THR_RST;
			upper_b <= ILD_THR_RST;
			dwell_b <= ILD_DWELL_RST;
			ctrl_a <= ILD_CTRL_RST;
			ctrl_b <= ILD_CTRL_RST;
		end else if (wr_ok) begin
			case (CHANNEL_ADDRESS_REG)
				ILD_LOWER_A: lower_a <= WDATA[ILD_THR_W-1:0];
				ILD_UPPER_A: upper_a <= WDATA[ILD_THR_W-1:0];
				ILD_DWELL_A: dwell_a <= WDATA;
				ILD_CTRL_A: ctrl_a <= WDATA[ILD_CTRL_W-1:0] & 5'h17;
				ILD_LOWER_B: lower_b <= WDATA[ILD_THR_W-1:0];
				ILD_UPPER_B: upper_b <= WDATA[ILD_THR_W-1:0];
				ILD_DWELL_B: dwell_b <= WDATA;
				ILD_CTRL_B: ctrl_b <= WDATA[ILD_CTRL_W-1:0] & 5'h17;
				default: begin
				end
			endcase
		end
	end

	// polarity and latency fields
	// one driver per struct: fields gathered from the separate registers
	assign cfg_a = {lower_a, upper_a, dwell_a, ctrl_a[ILD_POL_BIT], ctrl_a[ILD_LAT_LSB +: ILD_LAT_W]};
	assign cfg_b = {lower_b, upper_b, dwell_b, ctrl_b[ILD_POL_BIT], ctrl_b[ILD_LAT_LSB +: ILD_LAT_W]};

	// =========================================
	// read back
	always_comb begin
		next_rdata = '0;
		case (CHANNEL_ADDRESS_REG)
			ILD_LOWER_A: next_rdata = {10'h000, cfg_a.lower};
			ILD_UPPER_A: next_rdata = {10'h000, cfg_a.upper};
			ILD_DWELL_A: next_rdata = cfg_a.dwell;
			ILD_CTRL_A: next_rdata = {15'h0000, ctrl_a};
			ILD_LOWER_B: next_rdata = {10'h000, cfg_b.lower};
			ILD_UPPER_B: next_rdata = {10'h000, cfg_b.upper};
			ILD_DWELL_B: next_rdata = cfg_b.dwell;
			ILD_CTRL_B: next_rdata = {15'h0000, ctrl_b};
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= '0;
		end else if (RD && GAIN_CTRL_EN) begin
			RDATA <= next_rdata;
		end
	end

	// =========================================
	// two independent channels
	ild_detector u_det_a (
		.clk(CLK),
		.rst_b(RST_B),
		.sample(SAMPLE_A),
		.cfg(cfg_a),
		.active(act_a)
	);
	ild_detector u_det_b (
		.clk(CLK),
		.rst_b(RST_B),
		.sample(SAMPLE_B),
		.cfg(cfg_b),
		.active(act_b)
	);

	ild_delay u_del_a (
		.clk(CLK),
		.rst_b(RST_B),
		.din(act_a),
		.latency(cfg_a.latency),
		.dout(del_a)
	);
	ild_delay u_del_b (
		.clk(CLK),
		.rst_b(RST_B),
		.din(act_b),
		.latency(cfg_b.latency),
		.dout(del_b)
	);

	// =========================================
	// pins; registered so the pair never glitches apart
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			// inactive level after reset (polarity clear)
			GAIN_FLAG_A <= 1'b0;
			GAIN_FLAG_A_N <= 1'b1;
			GAIN_FLAG_B <= 1'b0;
			GAIN_FLAG_B_N <= 1'b1;
		end else begin
			GAIN_FLAG_A <= del_a ^ cfg_a.polarity;
			GAIN_FLAG_A_N <= ~(del_a ^ cfg_a.polarity);
			GAIN_FLAG_B <= del_b ^ cfg_b.polarity;
			GAIN_FLAG_B_N <= ~(del_b ^ cfg_b.polarity);
		end
	end

	// a_pair_complement
	a_pair_complement: assert property (@(posedge CLK) disable iff (!RST_B)
		(GAIN_FLAG_A != GAIN_FLAG_A_N) && (GAIN_FLAG_B != GAIN_FLAG_B_N))
		else $error("indicator pair not complementary");
	// a_pin_follows_active
	a_pin_follows_active: assert property (@(posedge CLK) disable iff (!RST_B)
		1'b1 |=> GAIN_FLAG_A == ($past(del_a) ^ $past(cfg_a.polarity)))
		else $error("indicator A level wrong");
	// a_reserved_zero
	a_reserved_zero: assert property (@(posedge CLK) disable iff (!RST_B)
		!ctrl_a[ILD_RSV_BIT] && !ctrl_b[ILD_RSV_BIT])
		else $error("reserved control bit set");
	// a_write_gated
	a_write_gated: assert property (@(posedge CLK) disable iff (!RST_B)
		(!GAIN_CTRL_EN) |=> $stable(cfg_a.lower) && $stable(cfg_b.dwell))
		else $error("register changed without access enable");
endmodule

// >>> sim/ild_gain_stage.sv
// bench model of the attenuator driven by one indicator pair
`timescale 1ns/1ps
module ild_gain_stage (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic flag,
	input wire logic flag_n,
	input wire logic polarity,
	output logic atten,
	output logic pair_bad
);
	// ===========================
	// decode
	// polarity decides which level means attenuate
	assign atten = flag ^ polarity;
	// sticky: a pair that ever agrees would confuse a real gain stage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pair_bad <= 1'b0;
		end else if (flag === flag_n) begin
			pair_bad <= 1'b1;
		end
	end
endmodule

// >>> sim/testbench.sv
// self-checking bench for the input level detector
`timescale 1ns/1ps
module testbench;
	import ild_pkg::*;
	// ===========================
	// stimulus and wiring
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic en = 1'b1;
	logic [2:0] addr = 3'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [19:0] wdata = 20'h00000;
	logic [19:0] rdata;
	logic [15:0] smp_a = 16'h0000;
	logic [15:0] smp_b = 16'h0000;
	logic pol_b = 1'b0;
	logic fa, fa_n, fb, fb_n, att_a, att_b, bad_a, bad_b;
	int num_errors = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	ild_top i_dut (.CLK(clk), .RST_B(rst_b), .GAIN_CTRL_EN(en), .CHANNEL_ADDRESS_REG(addr),
		.WR(wr), .RD(rd), .WDATA(wdata), .RDATA(rdata), .SAMPLE_A(smp_a), .SAMPLE_B(smp_b),
		.GAIN_FLAG_A(fa), .GAIN_FLAG_A_N(fa_n), .GAIN_FLAG_B(fb), .GAIN_FLAG_B_N(fb_n));
	ild_gain_stage i_att_a (.clk(clk), .rst_b(rst_b), .flag(fa), .flag_n(fa_n), .polarity(1'b0),
		.atten(att_a), .pair_bad(bad_a));
	ild_gain_stage i_att_b (.clk(clk), .rst_b(rst_b), .flag(fb), .flag_n(fb_n), .polarity(pol_b),
		.atten(att_b), .pair_bad(bad_b));
	// ===========================
	// shared tasks
	task automatic summarize();
		if (num_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [2:0] a, input logic [19:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask
	task automatic rreg(input logic [2:0] a, output logic [19:0] d);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		tick(1);
		d = rdata;
	endtask
	task automatic wait_a(output int n);
		n = 0;
		while (att_a !== 1'b1) begin
			n++;
			if (n > 40) begin
				num_errors++;
				$display("BAD wait_a exp 1 got 0");
				summarize();
			end
			tick(1);
		end
	endtask
	// ===========================
	// scenarios
	task automatic t_regs();
		logic [19:0] d;
		logic [19:0] m;
		chk("fa", 20'h0, {19'h0, fa});
		chk("fa_n", 20'h1, {19'h0, fa_n});
		for (int i = 0; i < 8; i++) begin
			m = (i % 4 == 2) ? 20'hfffff : ((i % 4 == 3) ? 20'h00017 : 20'h003ff);
			rreg(3'(i), d);
			chk("rst", 20'h0, d);
			wreg(3'(i), 20'hfffff);
			rreg(3'(i), d);
			chk("reg", m, d);
		end
		en = 1'b0;
		wreg(ILD_LOWER_A, 20'h00000);
		en = 1'b1;
		rreg(ILD_LOWER_A, d);
		chk("gated", 20'h003ff, d);
		for (int i = 0; i < 8; i++) begin
			wreg(3'(i), 20'h00000);
		end
	endtask
	task automatic t_detect(input logic [2:0] lat);
		int n;
		wreg(ILD_LOWER_A, 20'h00100);
		wreg(ILD_UPPER_A, 20'h00300);
		wreg(ILD_DWELL_A, 20'h00005);
		wreg(ILD_CTRL_A, {17'h0, lat});
		// exactly at the upper threshold
		smp_a = {10'h300, 6'h00};
		wait_a(n);
		chk("rise", 20'(2 + lat), 20'(n));
		chk("att_b", 20'h0, {19'h0, att_b});
		smp_a = {10'h100, 6'h3f};
		tick(3);
		chk("hold", 20'h1, {19'h0, att_a});
		// just above lower: the dwell count must restart
		smp_a = {10'h101, 6'h00};
		tick(8);
		smp_a = {10'h100, 6'h00};
		tick(3);
		chk("reload", 20'h1, {19'h0, att_a});
		tick(5 + lat);
		chk("release", 20'h0, {19'h0, att_a});
	endtask
	task automatic t_polar();
		wreg(ILD_LOWER_B, 20'h00100);
		wreg(ILD_UPPER_B, 20'h00200);
		wreg(ILD_DWELL_B, 20'h00002);
		wreg(ILD_CTRL_B, 20'h00010);
		pol_b = 1'b1;
		tick(2);
		chk("fb_idle", 20'h1, {19'h0, fb});
		smp_b = 16'hffc0;
		tick(4);
		chk("fb_act", 20'h0, {19'h0, fb});
		chk("fb_n_act", 20'h1, {19'h0, fb_n});
		chk("att_a", 20'h0, {19'h0, att_a});
		smp_b = 16'h0000;
		tick(6);
		chk("fb_rel", 20'h1, {19'h0, fb});
	endtask
	task automatic t_zero();
		wreg(ILD_DWELL_A, 20'h00001);
		wreg(ILD_CTRL_A, 20'h00000);
		// low bits set but top ten one below upper
		smp_a = {10'h2ff, 6'h3f};
		tick(5);
		chk("top_bits", 20'h0, {19'h0, att_a});
		wreg(ILD_DWELL_A, 20'h00000);
		smp_a = 16'hffff;
		tick(6);
		chk("dwell0", 20'h0, {19'h0, att_a});
		chk("pairs", 20'h0, {18'h0, bad_a, bad_b});
	endtask
	// ===========================
	// main sequence
	initial begin
		tick(3);
		rst_b = 1'b1;
		tick(1);
		t_regs();
		t_detect(3'h0);
		t_detect(3'h3);
		t_detect(3'h7);
		t_polar();
		t_zero();
		summarize();
	end
endmodule
